// ===== hw/srcap_ctrl.sv
// timing-reference capture control: polarity, edge, modes, skew window, timestamp delay
module srcap_ctrl
    import srcap_pkg::*;
#(
    parameter int DELAY_W = 7
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rstn,
    input  wire logic                     clk_en,
    input  wire logic [srcap_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [srcap_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [srcap_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                     sysref_in,
    input  wire logic                     ref_tick,
    output logic                          sysref_captured,
    output logic                          sysref_stamp,
    output logic                          irq
);
    import srcap_pkg::*;

    // refuse delay widths that the timestamp field cannot hold
    if (DELAY_W < 1 || DELAY_W > DATA_W - 1) begin : g_bad_delay_w
        $error("DELAY_W must lie between 1 and 7");
    end

    logic [7:0]          capture_reg;
    logic [7:0]          ignore_reg;
    logic [7:0]          skew_reg;
    logic [7:0]          tsdelay_reg;
    logic [7:0]          irq_mask_reg;
    logic [IRQ_W-1:0]    irq_stat_reg;
    logic [1:0]          flags_reg;
    logic [7:0]          cap_cnt_reg;
    logic                sysref_neg_reg;
    logic                samp_prev_reg;
    logic [EV_LAG-1:0]   ev_reg;
    logic [HIST_W-1:0]   ref_hist_reg;
    srcap_shot_t         shot_reg;
    srcap_mode_t         mode_prev_reg;
    logic [3:0]          skip_reg;
    logic [DELAY_W-1:0]  delay_cnt_reg;
    logic                delay_busy_reg;

    srcap_mode_t         mode;
    logic                samp;
    logic                valid_now;
    logic                ev_at;
    logic                on_edge;
    logic                in_win;
    logic                early_out;
    logic                late_out;
    logic                qual;
    logic                capture;
    logic                rd_stat;
    logic [IRQ_W-1:0]    irq_set;

    // true when a reference tick lies k = 1..w cycles away from the event slot
    function automatic logic win_hit(input logic [HIST_W-1:0] hist,
                                     input logic [WIN_W-1:0]  w,
                                     input logic              late);
        logic hit;
        hit = 1'b0;
        for (int k = 1; k <= WIN_MAX; k++) begin
            if (k <= int'(w))
                hit = hit | (late ? hist[WIN_MAX + k] : hist[WIN_MAX - k]);
        end
        return hit;
    endfunction

    assign mode           = srcap_mode_t'(capture_reg[MODE_LSB +: MODE_W]);
    assign rd_stat        = reg_rd && reg_addr == ADDR_IRQ_STAT;

    // ---- register writes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            capture_reg  <= CTRL_RESET;
            ignore_reg   <= CTRL_RESET;
            skew_reg     <= CTRL_RESET;
            tsdelay_reg  <= CTRL_RESET;
            irq_mask_reg <= CTRL_RESET;
        end else if (clk_en && reg_wr) begin
            unique case (reg_addr)
                ADDR_CAPTURE:  capture_reg  <= reg_wdata & CAPTURE_MASK;
                ADDR_IGNORE:   ignore_reg   <= reg_wdata & IGNORE_MASK;
                ADDR_SKEW:     skew_reg     <= reg_wdata & SKEW_MASK;
                ADDR_TSDELAY:  tsdelay_reg  <= reg_wdata & TSDELAY_MASK;
                ADDR_IRQ_MASK: irq_mask_reg <= reg_wdata & IRQ_MASK_MASK;
                default: ;
            endcase
        end
    end

    // ---- read port, data one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                unique case (reg_addr)
                    ADDR_CAPTURE:  reg_rdata <= capture_reg;
                    ADDR_IGNORE:   reg_rdata <= ignore_reg;
                    ADDR_SKEW:     reg_rdata <= skew_reg;
                    ADDR_TSDELAY:  reg_rdata <= tsdelay_reg;
                    ADDR_FLAGS:    reg_rdata <= {6'h00, flags_reg};
                    ADDR_IRQ_STAT: reg_rdata <= {5'h00, irq_stat_reg};
                    ADDR_IRQ_MASK: reg_rdata <= irq_mask_reg;
                    ADDR_CAP_CNT:  reg_rdata <= cap_cnt_reg;
                    default:       reg_rdata <= '0;
                endcase
            end
        end
    end

    // ---- sampling on the selected clock edge
    always_ff @(negedge ref_clk or negedge rstn) begin
        if (!rstn)
            sysref_neg_reg <= 1'b0;
        else if (clk_en)
            sysref_neg_reg <= sysref_in;
    end

    assign samp = capture_reg[EDGE_BIT] ? sysref_neg_reg : sysref_in;
    // software keeps the mode off while it changes polarity
    assign valid_now = capture_reg[POL_BIT] ? (samp_prev_reg && !samp)
                                            : (!samp_prev_reg && samp);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            samp_prev_reg <= 1'b0;
            ev_reg        <= '0;
            ref_hist_reg  <= '0;
        end else if (clk_en) begin
            samp_prev_reg <= samp;
            ev_reg        <= {ev_reg[EV_LAG-2:0], valid_now};
            ref_hist_reg  <= {ref_hist_reg[HIST_W-2:0], ref_tick};
        end
    end

    // ---- skew window classification at the lagged event slot
    assign ev_at     = ev_reg[EV_LAG-1];
    assign on_edge   = ref_hist_reg[WIN_MAX];
    assign in_win    = win_hit(ref_hist_reg, skew_reg[NEG_LSB +: WIN_W], 1'b0)
                     | win_hit(ref_hist_reg, skew_reg[POS_LSB +: WIN_W], 1'b1);
    assign early_out = |ref_hist_reg[WIN_MAX-1:0];
    assign late_out  = |ref_hist_reg[HIST_W-1:WIN_MAX+1];
    // window 00 gives in_win low, so only the exact edge avoids an error
    assign qual      = ev_at && (on_edge || !in_win);

    // ---- capture modes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            shot_reg      <= SHOT_IDLE;
            mode_prev_reg <= MODE_OFF;
            skip_reg      <= '0;
        end else if (clk_en) begin
            mode_prev_reg <= mode;
            unique case (shot_reg)
                SHOT_IDLE: if (mode == MODE_COUNTED && mode_prev_reg != MODE_COUNTED) begin
                    shot_reg <= SHOT_ARMED;
                    skip_reg <= ignore_reg[3:0];
                end
                SHOT_ARMED: begin
                    if (mode != MODE_COUNTED)
                        shot_reg <= SHOT_IDLE;
                    else if (qual && skip_reg != 4'h0)
                        skip_reg <= skip_reg - 4'h1;
                    else if (qual)
                        shot_reg <= SHOT_DONE;
                end
                SHOT_DONE: if (mode == MODE_OFF)
                    shot_reg <= SHOT_IDLE;
                default: shot_reg <= SHOT_IDLE;
            endcase
        end
    end

    always_comb begin
        unique case (mode)
            MODE_CONT:    capture = qual;
            MODE_COUNTED: capture = qual && shot_reg == SHOT_ARMED && skip_reg == 4'h0;
            default:      capture = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            sysref_captured <= 1'b0;
        else if (clk_en)
            sysref_captured <= capture;
    end

    // ---- timestamp delay, one pending capture, a new one restarts it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            delay_cnt_reg  <= '0;
            delay_busy_reg <= 1'b0;
            sysref_stamp   <= 1'b0;
        end else if (clk_en) begin
            sysref_stamp <= 1'b0;
            if (sysref_captured) begin
                delay_cnt_reg  <= tsdelay_reg[DELAY_W-1:0];
                delay_busy_reg <= tsdelay_reg[DELAY_W-1:0] != '0;
                sysref_stamp   <= tsdelay_reg[DELAY_W-1:0] == '0;
            end else if (delay_busy_reg) begin
                delay_cnt_reg <= delay_cnt_reg - DELAY_W'(1);
                if (delay_cnt_reg == DELAY_W'(1)) begin
                    delay_busy_reg <= 1'b0;
                    sysref_stamp   <= 1'b1;
                end
            end
        end
    end

    // ---- setup/hold flags and capture counter
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flags_reg   <= '0;
            cap_cnt_reg <= '0;
        end else if (clk_en) begin
            if (capture_reg[FLAG_RST_BIT]) begin
                flags_reg   <= '0;
                cap_cnt_reg <= '0;
            end else begin
                if (qual && !on_edge && early_out)
                    flags_reg[SETUP_ERR_BIT] <= 1'b1;
                if (qual && !on_edge && late_out)
                    flags_reg[HOLD_ERR_BIT] <= 1'b1;
                if (capture)
                    cap_cnt_reg <= cap_cnt_reg + 8'h01;
            end
        end
    end

    // ---- interrupts: read clears, a same-cycle set wins
    assign irq_set = {qual && !on_edge && (early_out || late_out),
                      ev_at && !qual,
                      capture};

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            irq_stat_reg <= '0;
        else if (clk_en)
            irq_stat_reg <= (rd_stat ? '0 : irq_stat_reg) | irq_set;
    end

    assign irq = |(irq_stat_reg & irq_mask_reg[IRQ_W-1:0]);

    // ---- assertions
    property p_polarity_rise;
        @(posedge ref_clk) disable iff (!rstn)
        clk_en && $past(clk_en) && !capture_reg[POL_BIT] && !capture_reg[EDGE_BIT]
            && !$past(sysref_in) && sysref_in |=> ev_reg[0];
    endproperty
    a_polarity_rise: assert property (p_polarity_rise) else $error("rising event misdetected");

    property p_polarity_fall;
        @(posedge ref_clk) disable iff (!rstn)
        clk_en && $past(clk_en) && capture_reg[POL_BIT] && !capture_reg[EDGE_BIT]
            && $past(sysref_in) && !sysref_in |=> ev_reg[0];
    endproperty
    a_polarity_fall: assert property (p_polarity_fall) else $error("falling event misdetected");

    property p_off_no_capture;
        @(posedge ref_clk) disable iff (!rstn)
        clk_en && (mode == MODE_OFF) |=> !sysref_captured;
    endproperty
    a_off_no_capture: assert property (p_off_no_capture) else $error("capture while off");

    property p_cont_capture;
        @(posedge ref_clk) disable iff (!rstn)
        clk_en && mode == MODE_CONT && ev_at && on_edge |=> sysref_captured;
    endproperty
    a_cont_capture: assert property (p_cont_capture) else $error("aligned event lost");

    property p_window_ignore;
        @(posedge ref_clk) disable iff (!rstn)
        clk_en && ev_at && !on_edge && in_win |=> !sysref_captured;
    endproperty
    a_window_ignore: assert property (p_window_ignore) else $error("windowed event captured");

    property p_exact_edge;
        @(posedge ref_clk) disable iff (!rstn)
        skew_reg[3:0] == 4'h0 |-> !in_win;
    endproperty
    a_exact_edge: assert property (p_exact_edge) else $error("zero window tolerated skew");

    property p_flag_reset;
        @(posedge ref_clk) disable iff (!rstn)
        clk_en && capture_reg[FLAG_RST_BIT] |=> flags_reg == 2'b00;
    endproperty
    a_flag_reset: assert property (p_flag_reset) else $error("flags not held clear");

    property p_done_quiet;
        @(posedge ref_clk) disable iff (!rstn)
        shot_reg == SHOT_DONE && mode == MODE_COUNTED |-> !capture;
    endproperty
    a_done_quiet: assert property (p_done_quiet) else $error("second counted capture");

    property p_stamp_zero;
        @(posedge ref_clk) disable iff (!rstn)
        clk_en && sysref_captured && tsdelay_reg[6:0] == 7'h00 |=> sysref_stamp;
    endproperty
    a_stamp_zero: assert property (p_stamp_zero) else $error("undelayed stamp late");

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (!rstn)
        (capture_reg & ~CAPTURE_MASK) == 8'h00 && (tsdelay_reg & ~TSDELAY_MASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    c_cont_capture: cover property (@(posedge ref_clk) disable iff (!rstn)
        mode == MODE_CONT && capture);
    c_counted_done: cover property (@(posedge ref_clk) disable iff (!rstn)
        shot_reg == SHOT_ARMED ##1 shot_reg == SHOT_DONE);
    c_window_skip: cover property (@(posedge ref_clk) disable iff (!rstn)
        ev_at && !qual);
    c_delayed_stamp: cover property (@(posedge ref_clk) disable iff (!rstn)
        sysref_stamp && tsdelay_reg[6:0] != 7'h00);
endmodule

// ===== inc/srcap_pkg.sv
// shared constants and types for the timing-reference capture control block
package srcap_pkg;
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 8;
    // register offsets
    localparam logic [11:0] ADDR_CAPTURE  = 12'h120;
    localparam logic [11:0] ADDR_IGNORE   = 12'h121;
    localparam logic [11:0] ADDR_SKEW     = 12'h122;
    localparam logic [11:0] ADDR_TSDELAY  = 12'h123;
    localparam logic [11:0] ADDR_FLAGS    = 12'h124;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h125;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h126;
    localparam logic [11:0] ADDR_CAP_CNT  = 12'h127;
    // capture_control fields
    localparam int          FLAG_RST_BIT  = 6;
    localparam int          POL_BIT       = 4;
    localparam int          EDGE_BIT      = 3;
    localparam int          MODE_LSB      = 1;
    localparam int          MODE_W        = 2;
    // writable masks, reserved bits read zero
    localparam logic [7:0]  CAPTURE_MASK  = 8'h5e;
    localparam logic [7:0]  IGNORE_MASK   = 8'h0f;
    localparam logic [7:0]  SKEW_MASK     = 8'h0f;
    localparam logic [7:0]  TSDELAY_MASK  = 8'h7f;
    localparam logic [7:0]  IRQ_MASK_MASK = 8'h07;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    // skew window fields
    localparam int          NEG_LSB       = 2;
    localparam int          POS_LSB       = 0;
    localparam int          WIN_W         = 2;
    localparam int          WIN_MAX       = 3;
    // event lag so that reference ticks after the event are already known
    localparam int          EV_LAG        = WIN_MAX + 1;
    localparam int          HIST_W        = 2 * WIN_MAX + 1;
    // status bits: flags register and interrupt status
    localparam int          SETUP_ERR_BIT = 0;
    localparam int          HOLD_ERR_BIT  = 1;
    localparam int          IRQ_CAP_BIT   = 0;
    localparam int          IRQ_IGN_BIT   = 1;
    localparam int          IRQ_ERR_BIT   = 2;
    localparam int          IRQ_W         = 3;

    typedef enum logic [1:0] {MODE_OFF, MODE_CONT, MODE_COUNTED, MODE_RSVD} srcap_mode_t;
    typedef enum logic [1:0] {SHOT_IDLE, SHOT_ARMED, SHOT_DONE} srcap_shot_t;
endpackage

// ===== verification/srcap_src_model.sv
// timing-reference source model: one transition per frame, tick at a chosen offset
module srcap_src_model (
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              start,
    input  wire logic signed [3:0] tick_off,
    output logic                   sysref_in,
    output logic                   ref_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt;

    // the line toggles once per frame, so rising and falling frames alternate
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt       <= 5'h00;
            sysref_in <= 1'b0;
            ref_tick  <= 1'b0;
        end else begin
            if (start) begin
                cnt <= 5'h01;
            end else if (cnt != 5'h00) begin
                cnt <= (cnt == 5'h10) ? 5'h00 : cnt + 5'h01;
            end
            if (cnt == 5'h08) begin
                sysref_in <= ~sysref_in;
            end
            // positive offset: tick after the transition, negative: before it
            ref_tick <= (cnt != 5'h00) && (int'(cnt) == 8 + int'(tick_off));
        end
    end
endmodule

// ===== verification/srcap_ctrl_test.sv
// self-checking bench for the timing-reference capture control block
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module srcap_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import srcap_pkg::*;
    logic              ref_clk, rstn, clk_en, reg_wr, reg_rd, start;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic              sysref_in, ref_tick, sysref_captured, sysref_stamp, irq;
    logic signed [3:0] off;
    logic [7:0]        ncap, n0, gap, sk;
    int                cyc, t_cap, errors, n_compared;
    logic [11:0]       ra[5] = '{ADDR_CAPTURE, ADDR_IGNORE, ADDR_SKEW, ADDR_TSDELAY, ADDR_IRQ_MASK};
    logic [7:0]        rm[5] = '{8'h5e, 8'h0f, 8'h0f, 8'h7f, 8'h07};
    logic [7:0]        ig[3] = '{8'h00, 8'h03, 8'h0f};
    logic [7:0]        dl[4] = '{8'h00, 8'h01, 8'h05, 8'h7f};

    srcap_ctrl #(.DELAY_W(7)) u_dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sysref_in(sysref_in), .ref_tick(ref_tick),
        .sysref_captured(sysref_captured), .sysref_stamp(sysref_stamp), .irq(irq));
    srcap_src_model u_src (.ref_clk(ref_clk), .rstn(rstn), .start(start), .tick_off(off),
        .sysref_in(sysref_in), .ref_tick(ref_tick));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // capture count and capture-to-stamp distance
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (sysref_captured === 1'b1) begin
            ncap  <= ncap + 8'h01;
            t_cap <= cyc;
        end
        if (sysref_stamp === 1'b1) begin
            gap <= 8'(cyc - t_cap);
        end
    end

    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input bit c = 1'b1);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        if (c) `CHK("rdata", e, reg_rdata)
    endtask

    task automatic frame(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            start <= 1'b1;
            @(posedge ref_clk);
            start <= 1'b0;
            repeat (22) @(posedge ref_clk);
        end
    endtask

    // one frame with the valid transition, then one with the opposite one
    task automatic pol_pair(input logic p, input logic [7:0] e);
        if (sysref_in !== p) frame(1);
        n0 = ncap;
        frame(1);
        `CHK("captures", 8'(n0 + e), ncap)
        frame(1);
        `CHK("captures", 8'(n0 + e), ncap)
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        summarize();
    end

    initial begin
        {rstn, clk_en, reg_wr, reg_rd, start} = 5'b00000;
        {reg_addr, reg_wdata, ncap, gap, off} = '0;
        {cyc, t_cap, errors, n_compared} = '0;
        repeat (20) @(posedge ref_clk);
        rstn   <= 1'b1;
        clk_en <= 1'b1;
        for (int i = 0; i < 8; i++) rd(ADDR_CAPTURE + 12'(i), 8'h00);
        foreach (ra[i]) begin
            wr(ra[i], 8'hff);
            rd(ra[i], rm[i]);
            wr(ra[i], 8'h00);
        end
        wr(ADDR_FLAGS, 8'hff);
        rd(ADDR_FLAGS, 8'h00);
        rd(12'h130, 8'h00);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(ADDR_TSDELAY, 8'h55);
        clk_en <= 1'b1;
        rd(ADDR_TSDELAY, 8'h00);
        // disabled and reserved modes capture nothing
        pol_pair(1'b0, 8'h00);
        wr(ADDR_CAPTURE, 8'h06);
        pol_pair(1'b0, 8'h00);
        // polarity changed only while capture is disabled
        for (int p = 0; p < 2; p++) begin
            for (int e = 0; e < 2; e++) begin
                wr(ADDR_CAPTURE, 8'h00);
                wr(ADDR_CAPTURE, 8'(p << POL_BIT | e << EDGE_BIT));
                wr(ADDR_CAPTURE, 8'(p << POL_BIT | e << EDGE_BIT | 2));
                pol_pair(p[0], 8'h01);
            end
        end
        wr(ADDR_CAPTURE, 8'h00);
        // counted mode: skip, capture once, stay done until rearmed
        foreach (ig[i]) begin
            wr(ADDR_IGNORE, ig[i]);
            wr(ADDR_CAPTURE, 8'h00);
            wr(ADDR_CAPTURE, 8'h04);
            n0 = ncap;
            frame(2 * int'(ig[i]));
            `CHK("captures", n0, ncap)
            frame(2);
            `CHK("captures", 8'(n0 + 1), ncap)
            frame(4);
            `CHK("captures", 8'(n0 + 1), ncap)
            wr(ADDR_CAPTURE, 8'h04);
            frame(2);
            `CHK("captures", 8'(n0 + 1), ncap)
        end
        // skew windows: inside the window ignored, just outside captured and flagged
        for (int s = 0; s < 2; s++) begin
            for (int k = 1; k <= 3; k++) begin
                for (int w = 0; w < 2; w++) begin
                    wr(ADDR_CAPTURE, 8'h42);
                    rd(ADDR_FLAGS, 8'h00);
                    rd(ADDR_CAP_CNT, 8'h00);
                    rd(ADDR_IRQ_STAT, 8'h00, 1'b0);
                    sk = 8'(k - w);
                    wr(ADDR_SKEW, s ? sk << POS_LSB : sk << NEG_LSB);
                    wr(ADDR_CAPTURE, 8'h02);
                    off <= s ? -4'(k) : 4'(k);
                    n0 = ncap;
                    frame(2);
                    `CHK("captures", 8'(n0 + w), ncap)
                    rd(ADDR_FLAGS, w ? (s ? 8'h02 : 8'h01) : 8'h00);
                    rd(ADDR_IRQ_STAT, w ? 8'h05 : 8'h02);
                    rd(ADDR_CAP_CNT, 8'(w));
                end
            end
        end
        wr(ADDR_SKEW, 8'h00);
        off <= 4'sh0;
        // interrupt: masked in, cleared by read, masked out
        wr(ADDR_IRQ_MASK, 8'h01);
        rd(ADDR_IRQ_STAT, 8'h00, 1'b0);
        frame(2);
        `CHK("irq", 1'b1, irq)
        rd(ADDR_IRQ_STAT, 8'h01);
        `CHK("irq", 1'b0, irq)
        wr(ADDR_IRQ_MASK, 8'h00);
        frame(2);
        `CHK("irq", 1'b0, irq)
        rd(ADDR_IRQ_STAT, 8'h01);
        // timestamp delay from capture pulse to stamp pulse
        foreach (dl[i]) begin
            wr(ADDR_TSDELAY, dl[i]);
            frame(2);
            repeat (130) @(posedge ref_clk);
            `CHK("stamp_gap", (dl[i] == 8'h00) ? 8'h01 : dl[i] + 8'h01, gap)
        end
        summarize();
    end
endmodule
